// ==== rtl/pmic_i2c_pkg.sv ====
// Constants, types and helpers shared by the serial slave port and its register store
// Summary of operation
// R01 - I2C slave register access, SCL to 400 kHz
// R02 - First write byte is 8-bit register address
// R03 - Power-up loads registers from stored defaults
// R04 - Supply below lockout restores all defaults
// R05 - Acknowledge only 0x90 and 0x91 addresses
// R06 - No auto-increment; one register per read
// R07 - Slave never creates START or STOP; sleep and the R10 release can move data with SCL high
// R08 - Sleep mode holds data line low
// R09 - Release data line before enabling regulators
// R10 - Release stuck data line after 10 clocks
// R11 - Host sends 10 clocks to recover bus
// R12 - Reset output low while holding system reset
// R13 - Low system bus sense enters sleep mode
// R14 - Acknowledge bytes in ninth clock, then release
// R15 - Commit write at trailing acknowledge edge only
// R16 - Refused register address: NACK, pointer unchanged
// R17 - STOP returns to wait; repeated START is START
// R18 - Synchronise and filter SCL and SDA inputs
package pmic_i2c_pkg;

  localparam int CLK_MHZ        = 100;
  localparam int SCL_MAX_KHZ    = 400;
  // Shortest SCL half period in clock cycles, rounded down
  localparam int SCL_HALF_CYC   = (CLK_MHZ * 1000) / (2 * SCL_MAX_KHZ);
  // Glitch filter length, far below the shortest half period
  localparam int FILT_LEN       = SCL_HALF_CYC / 32;
  localparam int FILT_W         = 3;

  localparam logic [7:0] DEV_ADDR_WRITE = 8'h90;
  localparam logic [7:0] DEV_ADDR_READ  = 8'h91;

  localparam int          REG_COUNT      = 40;
  localparam int          REG_AW         = 6;
  localparam logic [7:0]  REG_FIRST_OK   = 8'h02;
  localparam logic [7:0]  REG_LAST_OK    = 8'h27;
  localparam logic [7:0]  REG_POWER_GOOD = 8'h02;
  localparam logic [7:0]  REG_CHG_STATUS = 8'h0a;
  localparam logic [7:0]  REG_ADC_HI     = 8'h1f;
  localparam logic [7:0]  REG_ADC_LO     = 8'h20;
  localparam logic [7:0]  REG_DEFAULT    = 8'h00;
  localparam logic [7:0]  PTR_RESET      = 8'h02;

  localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
  localparam logic [3:0]  RECOVER_PULSES = 4'ha;

  typedef enum logic [2:0] {
    ST_WAIT,
    ST_ADDR,
    ST_CMD,
    ST_WDATA,
    ST_RDATA,
    ST_RACK
  } slaveState_t;

  function automatic logic isAllowed(input logic [7:0] a);
    return (a >= REG_FIRST_OK) && (a <= REG_LAST_OK);
  endfunction

  function automatic logic isWritable(input logic [7:0] a);
    return isAllowed(a) && (a != REG_POWER_GOOD) && (a != REG_CHG_STATUS)
           && (a != REG_ADC_HI) && (a != REG_ADC_LO);
  endfunction

endpackage

// ==== rtl/reg_store_if.sv ====
// Carrier between the slave port control and its register store
`timescale 1ns/1ps
`default_nettype none
interface reg_store_if
  import pmic_i2c_pkg::*;
  ();
  logic              wrEn;
  logic [REG_AW-1:0] wrAddr;
  logic [7:0]        wrData;
  logic [REG_AW-1:0] rdAddr;
  logic [7:0]        rdData;
  logic              loading;

  modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr,
                input rdData, input loading);
  modport store (input wrEn, input wrAddr, input wrData, input rdAddr,
                 output rdData, output loading);
endinterface
`default_nettype wire

// ==== rtl/reg_store.sv ====
// Register store with default reload walk and registered read data
`timescale 1ns/1ps
`default_nettype none
module reg_store
  import pmic_i2c_pkg::*;
(
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   reset,
  input  wire logic   clkEn,
  // Hold the default walk at its start while high; it restores all once low
  input  wire logic   reload,
  // Port side
  reg_store_if.store  bus
);

  logic [7:0]        mem [0:REG_COUNT-1];
  logic              loading_q;
  logic [REG_AW-1:0] walk_q;
  logic [7:0]        rdData_q;

  wire walkLast = (walk_q == REG_AW'(REG_COUNT - 1));

  assign bus.loading = loading_q;
  assign bus.rdData  = rdData_q;

  // Reset and lockout both start a full walk; writes are dropped until it ends
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      loading_q <= 1'b1; // R03
      walk_q    <= '0;
    end else if (clkEn) begin
      if (reload) begin
        loading_q <= 1'b1; // R04
        walk_q    <= '0;
      end else if (loading_q) begin
        loading_q <= !walkLast;
        walk_q    <= walk_q + REG_AW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (clkEn) begin
      if (loading_q) begin
        mem[walk_q] <= REG_DEFAULT; // R03 R04
      end else if (bus.wrEn) begin
        mem[bus.wrAddr] <= bus.wrData;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdData_q <= REG_DEFAULT;
    end else if (clkEn) begin
      rdData_q <= mem[bus.rdAddr];
    end
  end

endmodule
`default_nettype wire

// ==== rtl/pmic_i2c_slave_port.sv ====
// Serial register slave port with sleep hold, bus recovery and reset pin
`timescale 1ns/1ps
`default_nettype none
module pmic_i2c_slave_port
  import pmic_i2c_pkg::*;
(
  // Clock, reset, enable
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic clkEn,
  // Serial bus pins
  input  wire logic serialClockPin,
  input  wire logic serialDataPinIn,
  output logic      serialDataPinOut,
  output logic      serialDataPinOeN,
  // Supply monitors, high when below threshold
  input  wire logic systemBusSense,
  input  wire logic supplyLockoutThreshold,
  // System reset pin
  input  wire logic holdSystemReset,
  output logic      systemResetOut,
  output logic      systemResetOutOeN,
  // Power state
  output logic      sleepMode,
  output logic      regulatorEnable
);

  // Two-stage synchronisers for the clock, data and supply monitor pin inputs
  logic [1:0] sclSync_q;
  logic [1:0] sdaSync_q;
  logic [1:0] senseSync_q;
  logic [1:0] lockSync_q;

  reg_store_if regBus ();

  reg_store u_store (
    .clk    (clk),
    .reset  (reset),
    .clkEn  (clkEn),
    .reload (lockSync_q[1]),
    .bus    (regBus)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
    end else if (clkEn) begin
      sclSync_q <= {sclSync_q[0], serialClockPin}; // R18
      sdaSync_q <= {sdaSync_q[0], serialDataPinIn}; // R18
    end
  end

  // Supply monitors are slow levels; two stages are enough
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      senseSync_q <= 2'h0;
      lockSync_q  <= 2'h0;
    end else if (clkEn) begin
      senseSync_q <= {senseSync_q[0], systemBusSense};
      lockSync_q  <= {lockSync_q[0], supplyLockoutThreshold};
    end
  end

  // Filter: a level must hold FILT_LEN cycles before it is believed
  logic              sclFilt_q;
  logic              sdaFilt_q;
  logic [FILT_W-1:0] sclCnt_q;
  logic [FILT_W-1:0] sdaCnt_q;
  logic              sclPrev_q;
  logic              sdaPrev_q;

  wire sclDiff = (sclSync_q[1] != sclFilt_q);
  wire sdaDiff = (sdaSync_q[1] != sdaFilt_q);
  wire sclFlip = sclDiff && (sclCnt_q == FILT_W'(FILT_LEN - 1)); // R01
  wire sdaFlip = sdaDiff && (sdaCnt_q == FILT_W'(FILT_LEN - 1));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclFilt_q <= 1'b1;
      sclCnt_q  <= '0;
      sclPrev_q <= 1'b1;
    end else if (clkEn) begin
      sclCnt_q  <= (sclDiff && !sclFlip) ? sclCnt_q + FILT_W'(1) : '0; // R18
      sclFilt_q <= sclFlip ? sclSync_q[1] : sclFilt_q;
      sclPrev_q <= sclFilt_q;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sdaFilt_q <= 1'b1;
      sdaCnt_q  <= '0;
      sdaPrev_q <= 1'b1;
    end else if (clkEn) begin
      sdaCnt_q  <= (sdaDiff && !sdaFlip) ? sdaCnt_q + FILT_W'(1) : '0; // R18
      sdaFilt_q <= sdaFlip ? sdaSync_q[1] : sdaFilt_q;
      sdaPrev_q <= sdaFilt_q;
    end
  end

  // Bus events
  wire sclRise  = sclFilt_q && !sclPrev_q;
  wire sclFall  = !sclFilt_q && sclPrev_q;
  wire startSeen = sclFilt_q && sclPrev_q && !sdaFilt_q && sdaPrev_q; // R17
  wire stopSeen  = sclFilt_q && sclPrev_q && sdaFilt_q && !sdaPrev_q; // R17

  // Slave state
  slaveState_t state_q;
  logic [3:0]  bitCnt_q;
  logic [7:0]  rxShift_q;
  logic [7:0]  txShift_q;
  logic        ackPhase_q;
  logic        sdaDrive_q;
  logic        pendWr_q;
  logic [7:0]  wrData_q;
  logic [7:0]  ptr_q;
  logic [3:0]  recCnt_q;
  logic        wrEn_q;

  wire byteDone   = (bitCnt_q == BITS_PER_BYTE);
  wire isWriteAdr = (rxShift_q == DEV_ADDR_WRITE);
  wire isReadAdr  = (rxShift_q == DEV_ADDR_READ);
  wire cmdOk      = isAllowed(rxShift_q);
  wire dataOk     = isWritable(ptr_q);
  wire recovered  = (recCnt_q == RECOVER_PULSES);
  wire inByte     = (state_q == ST_ADDR) || (state_q == ST_CMD) || (state_q == ST_WDATA);

  assign regBus.rdAddr = ptr_q[REG_AW-1:0];
  assign regBus.wrAddr = ptr_q[REG_AW-1:0];
  assign regBus.wrData = wrData_q;
  assign regBus.wrEn   = wrEn_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q    <= ST_WAIT;
      bitCnt_q   <= '0;
      rxShift_q  <= '0;
      txShift_q  <= '0;
      ackPhase_q <= 1'b0;
      sdaDrive_q <= 1'b0;
      pendWr_q   <= 1'b0;
      wrData_q   <= '0;
      ptr_q      <= PTR_RESET;
      recCnt_q   <= '0;
      wrEn_q     <= 1'b0;
    end else if (clkEn) begin
      wrEn_q <= 1'b0;
      if (lockSync_q[1]) begin
        ptr_q <= PTR_RESET; // R04
      end
      if (startSeen) begin
        // START and repeated START both restart address reception
        state_q    <= ST_ADDR; // R17
        bitCnt_q   <= '0;
        ackPhase_q <= 1'b0;
        sdaDrive_q <= 1'b0;
        pendWr_q   <= 1'b0; // R15
        recCnt_q   <= '0;
      end else if (stopSeen) begin
        state_q    <= ST_WAIT; // R17
        ackPhase_q <= 1'b0;
        sdaDrive_q <= 1'b0;
        pendWr_q   <= 1'b0; // R15
        recCnt_q   <= '0;
      end else if ((state_q != ST_WAIT) || ackPhase_q) begin
        if (sclRise && sdaDrive_q) begin
          recCnt_q <= recCnt_q + 4'h1;
        end
        if (recovered) begin
          // Host clocked long enough: give the data line back
          state_q    <= ST_WAIT; // R10
          sdaDrive_q <= 1'b0; // R10
          ackPhase_q <= 1'b0;
          pendWr_q   <= 1'b0;
          recCnt_q   <= '0;
        end else if (sclRise && !ackPhase_q) begin
          if (inByte) begin
            rxShift_q <= {rxShift_q[6:0], sdaFilt_q};
            bitCnt_q  <= bitCnt_q + 4'h1;
          end else if (state_q == ST_RDATA) begin
            bitCnt_q  <= bitCnt_q + 4'h1;
          end else if (state_q == ST_RACK) begin
            // Host ack or nack alike: no further byte is offered
            state_q   <= ST_WAIT; // R06
          end
        end else if (sclFall) begin
          if (ackPhase_q) begin
            // Trailing edge of the ack clock
            ackPhase_q <= 1'b0;
            bitCnt_q   <= '0;
            recCnt_q   <= '0;
            if (pendWr_q) begin
              wrEn_q   <= !regBus.loading; // R15
              pendWr_q <= 1'b0;
            end
            if (state_q == ST_RDATA) begin
              txShift_q  <= {regBus.rdData[6:0], 1'b1};
              sdaDrive_q <= !regBus.rdData[7];
            end else begin
              sdaDrive_q <= 1'b0; // R14
            end
          end else if (inByte && byteDone) begin
            bitCnt_q <= '0;
            case (state_q)
              ST_ADDR: begin
                if (isWriteAdr || isReadAdr) begin
                  ackPhase_q <= 1'b1; // R05
                  sdaDrive_q <= 1'b1; // R14
                  state_q    <= isReadAdr ? ST_RDATA : ST_CMD;
                end else begin
                  state_q    <= ST_WAIT; // R05
                end
              end
              ST_CMD: begin
                if (cmdOk) begin
                  ptr_q      <= rxShift_q; // R02
                  ackPhase_q <= 1'b1;
                  sdaDrive_q <= 1'b1; // R14
                  state_q    <= ST_WDATA;
                end else begin
                  state_q    <= ST_WAIT; // R16
                end
              end
              ST_WDATA: begin
                if (dataOk) begin
                  wrData_q   <= rxShift_q;
                  pendWr_q   <= 1'b1; // R15
                  ackPhase_q <= 1'b1;
                  sdaDrive_q <= 1'b1; // R14
                end
                state_q <= ST_WAIT;
              end
              default: begin
                state_q <= ST_WAIT;
              end
            endcase
          end else if (state_q == ST_RDATA) begin
            if (byteDone) begin
              sdaDrive_q <= 1'b0;
              state_q    <= ST_RACK;
            end else begin
              sdaDrive_q <= !txShift_q[7];
              txShift_q  <= {txShift_q[6:0], 1'b1};
            end
          end
        end
      end
    end
  end

  // A write is decided before WAIT so the ack still runs; keep the ack alive there
  wire portDrive = sdaDrive_q && ((state_q != ST_WAIT) || ackPhase_q);

  // Ack of a final data byte is also held low by this small tail while in WAIT
  logic tailAck_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tailAck_q <= 1'b0;
    end else if (clkEn) begin
      tailAck_q <= ackPhase_q && (state_q == ST_WAIT) && !sclFall && !startSeen && !stopSeen;
    end
  end

  // Sleep, regulator and reset pin control
  logic sleep_q;
  logic regEn_q;
  logic rstDrive_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sleep_q <= 1'b0;
    end else if (clkEn) begin
      sleep_q <= senseSync_q[1]; // R13
    end
  end

  // Enable follows the release by a cycle so the line is already free
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regEn_q <= 1'b0;
    end else if (clkEn) begin
      regEn_q <= !sleep_q && !senseSync_q[1]; // R09
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rstDrive_q <= 1'b1;
    end else if (clkEn) begin
      rstDrive_q <= holdSystemReset; // R12
    end
  end

  // Open drain: only ever pulls low, yet sleep and the R10 release can still make a START or STOP
  assign serialDataPinOut  = 1'b0; // R07
  assign serialDataPinOeN  = !(sleep_q || portDrive || tailAck_q); // R08
  assign systemResetOut    = 1'b0;
  assign systemResetOutOeN = !rstDrive_q; // R12
  assign sleepMode         = sleep_q;
  assign regulatorEnable   = regEn_q;

endmodule
`default_nettype wire

// ==== tb/pmic_i2c_slave_port_asserts.sv ====
// Pin-level properties of the serial slave port
`timescale 1ns/1ps
`default_nettype none
module pmic_i2c_slave_port_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Watched pins
  input wire logic serialClockPin,
  input wire logic serialDataPinOut,
  input wire logic serialDataPinOeN,
  input wire logic systemBusSense,
  input wire logic holdSystemReset,
  input wire logic systemResetOut,
  input wire logic systemResetOutOeN,
  input wire logic sleepMode,
  input wire logic regulatorEnable
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Clock rises seen while the port holds data low
  logic [4:0] riseCount_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      riseCount_q <= 5'h00;
    end else if (serialDataPinOeN || sleepMode) begin
      riseCount_q <= 5'h00;
    end else if ($rose(serialClockPin) && riseCount_q != 5'h1f) begin
      riseCount_q <= riseCount_q + 5'h01;
    end
  end

  open_drain_low_a: assert property (!serialDataPinOut && !systemResetOut)
    else $error("Open-drain data not low");
  reset_pin_a: assert property (!$past(reset) |-> systemResetOutOeN == !$past(holdSystemReset))
    else $error("Reset pin does not follow hold");
  sleep_hold_a: assert property (sleepMode |-> !serialDataPinOeN)
    else $error("Data line free in sleep");
  sleep_entry_a: assert property (systemBusSense [*5] |-> sleepMode)
    else $error("Low bus sense did not sleep");
  sleep_exit_a: assert property ($fell(sleepMode) |->
    serialDataPinOeN && !regulatorEnable ##1 regulatorEnable)
    else $error("Wake order wrong");
  regs_off_a: assert property (sleepMode && $past(sleepMode) |-> !regulatorEnable)
    else $error("Regulators on in sleep");
  no_start_a: assert property ($fell(serialDataPinOeN) && !sleepMode |-> !serialClockPin)
    else $error("Data pulled while clock high");
  ack_release_a: assert property ($rose(serialDataPinOeN) && !$past(sleepMode)
    && $past(riseCount_q) != 5'h0a |-> !serialClockPin)
    else $error("Data released while clock high");
  stuck_limit_a: assert property (riseCount_q <= 5'h0a)
    else $error("Data held past ten pulses");
endmodule

bind pmic_i2c_slave_port pmic_i2c_slave_port_asserts chk (
  .clk(clk), .reset(reset), .serialClockPin(serialClockPin),
  .serialDataPinOut(serialDataPinOut), .serialDataPinOeN(serialDataPinOeN),
  .systemBusSense(systemBusSense), .holdSystemReset(holdSystemReset),
  .systemResetOut(systemResetOut), .systemResetOutOeN(systemResetOutOeN),
  .sleepMode(sleepMode), .regulatorEnable(regulatorEnable)
);
`default_nettype wire

// ==== tb/i2c_host_model.sv ====
// Behavioural bus host driving clock and data toward the slave port
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  // Pacing clock
  input  wire logic clk,
  // Bus lines
  input  wire logic sdaLine,
  output logic      sclOut,
  output logic      sdaOeN
);
  // Quarter bit in clocks keeps the bus at or below 400 kHz
  localparam int QTR = 63;

  initial begin
    sclOut = 1'b1;
    sdaOeN = 1'b1;
  end

  task automatic waitQ(input int n);
    repeat (n * QTR) @(posedge clk);
  endtask

  // One pulse; level is taken mid-high when data is stable
  task automatic bitCycle(input logic d, output logic r);
    sdaOeN <= d;
    waitQ(1);
    sclOut <= 1'b1;
    waitQ(1);
    r = sdaLine;
    waitQ(1);
    sclOut <= 1'b0;
    waitQ(1);
  endtask

  // Also a repeated start from a low clock
  task automatic startCond();
    sdaOeN <= 1'b1;
    waitQ(1);
    sclOut <= 1'b1;
    waitQ(1);
    sdaOeN <= 1'b0;
    waitQ(1);
    sclOut <= 1'b0;
    waitQ(1);
  endtask

  task automatic stopCond();
    sdaOeN <= 1'b0;
    waitQ(1);
    sclOut <= 1'b1;
    waitQ(1);
    sdaOeN <= 1'b1;
    waitQ(2);
  endtask

  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(b[i], r);
    end
    bitCycle(1'b1, r);
    ack = !r;
  endtask

  // Only one byte per read; the caller ends it
  task automatic recvByte(output logic [7:0] d, input logic ackIt);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(1'b1, d[i]);
    end
    bitCycle(!ackIt, r);
  endtask

  task automatic recover();
    logic r;
    for (int i = 0; i < 10; i++) begin
      bitCycle(1'b1, r);
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the serial slave port
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) \
  begin \
    testsRun++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module testbench;
  logic       clk;
  logic       reset;
  logic       clkEn;
  logic       busLow;
  logic       lockout;
  logic       holdReset;
  logic       sclLine;
  logic       hostSdaOeN;
  logic       sdaOut;
  logic       sdaOeN;
  logic       rstOut;
  logic       rstOeN;
  logic       sleepMode;
  logic       regEn;
  wire logic  sdaLine;
  int         mismatches;
  int         testsRun;
  logic [7:0] rd;
  logic [2:0] acks;

  // Pull-up wins unless a party pulls low
  assign sdaLine = hostSdaOeN & (sdaOeN | sdaOut);

  pmic_i2c_slave_port dut (
    .clk(clk), .reset(reset), .clkEn(clkEn), .serialClockPin(sclLine),
    .serialDataPinIn(sdaLine), .serialDataPinOut(sdaOut), .serialDataPinOeN(sdaOeN),
    .systemBusSense(busLow), .supplyLockoutThreshold(lockout),
    .holdSystemReset(holdReset), .systemResetOut(rstOut), .systemResetOutOeN(rstOeN),
    .sleepMode(sleepMode), .regulatorEnable(regEn)
  );
  i2c_host_model host (.clk(clk), .sdaLine(sdaLine), .sclOut(sclLine), .sdaOeN(hostSdaOeN));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic addrPhase(input logic [7:0] cmd);
    host.startCond();
    host.sendByte(8'h90, acks[2]);
    host.sendByte(cmd, acks[1]);
  endtask

  task automatic readPtr();
    host.startCond();
    host.sendByte(8'h91, acks[0]);
    host.recvByte(rd, 1'b0);
    host.stopCond();
  endtask

  task automatic scnPowerUp();
    host.recover();
    readPtr();
    `CHECK(acks[0], 1'b1)
    `CHECK(rd, 8'h00)
    @(posedge clk) holdReset <= 1'b1;
    repeat (3) @(posedge clk);
    `CHECK(rstOeN, 1'b0)
    holdReset <= 1'b0;
    repeat (3) @(posedge clk);
    `CHECK(rstOeN, 1'b1)
  endtask

  task automatic scnWriteRead();
    addrPhase(8'h05);
    host.sendByte(8'h3c, acks[0]);
    host.stopCond();
    `CHECK(acks, 3'b111)
    addrPhase(8'h05);
    readPtr();
    `CHECK(acks, 3'b111)
    `CHECK(rd, 8'h3c)
  endtask

  task automatic scnRefusals();
    logic [7:0] badDev [3] = '{8'h00, 8'h92, 8'hff};
    logic [7:0] badCmd [3] = '{8'h00, 8'h28, 8'h2e};
    logic       a;
    foreach (badDev[i]) begin
      host.startCond();
      host.sendByte(badDev[i], a);
      host.stopCond();
      `CHECK(a, 1'b0)
    end
    foreach (badCmd[i]) begin
      addrPhase(badCmd[i]);
      host.stopCond();
      `CHECK(acks[2:1], 2'b10)
    end
    readPtr();
    `CHECK(rd, 8'h3c)
    addrPhase(8'h0a);
    host.sendByte(8'h55, acks[0]);
    host.stopCond();
    `CHECK(acks, 3'b110)
    readPtr();
    `CHECK(rd, 8'h00)
  endtask

  task automatic scnSleepLockout();
    int n;
    @(posedge clk) busLow <= 1'b1;
    repeat (10) @(posedge clk);
    `CHECK(sleepMode, 1'b1)
    `CHECK(sdaOeN, 1'b0)
    busLow <= 1'b0;
    n = 0;
    while (regEn !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) begin
      mismatches++;
      tally_and_finish();
    end
    `CHECK(sdaOeN, 1'b1)
    lockout <= 1'b1;
    repeat (10) @(posedge clk);
    lockout <= 1'b0;
    repeat (60) @(posedge clk);
    addrPhase(8'h05);
    readPtr();
    `CHECK(rd, 8'h00)
    host.startCond();
    host.sendByte(8'h91, acks[0]);
    host.recover();
    `CHECK(sdaLine, 1'b1)
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    reset = 1'b1;
    clkEn = 1'b1;
    busLow = 1'b0;
    lockout = 1'b0;
    holdReset = 1'b0;
    mismatches = 0;
    testsRun = 0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (50) @(posedge clk);
    scnPowerUp();
    scnWriteRead();
    scnRefusals();
    scnSleepLockout();
    tally_and_finish();
  end
endmodule
`default_nettype wire
